// File: hw/wwds_pkg.sv
// constants, strap encodings and carrier types of the window watchdog
package wwds_pkg;

    // ********************************************************************
    // clock and timing figures
    // ********************************************************************
    localparam int CLK_MHZ = 50;
    // times in microseconds, typical values
    localparam int RELEASE_DELAY_US = 25000;
    localparam int TOUT_SHORT_US = 250000;
    localparam int TOUT_LONG_US = 2500000;
    localparam int LOW_SHORT_RLO_US = 7860;
    localparam int LOW_SHORT_RHI_US = 2000;
    localparam int LOW_LONG_RLO_US = 78200;
    localparam int LOW_LONG_RHI_US = 19600;
    // cycle counts derived from the times
    localparam logic [31:0] RELEASE_DELAY_CYC =
        32'(RELEASE_DELAY_US * CLK_MHZ);
    localparam logic [31:0] TOUT_SHORT_CYC = 32'(TOUT_SHORT_US * CLK_MHZ);
    localparam logic [31:0] TOUT_LONG_CYC = 32'(TOUT_LONG_US * CLK_MHZ);
    localparam logic [31:0] LOW_SHORT_RLO_CYC =
        32'(LOW_SHORT_RLO_US * CLK_MHZ);
    localparam logic [31:0] LOW_SHORT_RHI_CYC =
        32'(LOW_SHORT_RHI_US * CLK_MHZ);
    localparam logic [31:0] LOW_LONG_RLO_CYC = 32'(LOW_LONG_RLO_US * CLK_MHZ);
    localparam logic [31:0] LOW_LONG_RHI_CYC = 32'(LOW_LONG_RHI_US * CLK_MHZ);
    // capacitor window ratios, times ten: 1:25.8 and 1:64.5
    localparam logic [63:0] RATIO_X10_SCALE = 64'h000000000000000a;
    localparam logic [63:0] RATIO_LO_X10 = 64'h0000000000000102;
    localparam logic [63:0] RATIO_HI_X10 = 64'h0000000000000285;
    // reset values
    localparam logic [31:0] CNT_RST = 32'h00000000;
    localparam logic [4:0] PINS_RST = 5'h00;

    // ********************************************************************
    // types
    // ********************************************************************
    typedef enum logic [1:0] {
        TSEL_LOW = 2'b00,
        TSEL_HIGH = 2'b01,
        TSEL_CAP = 2'b10
    } wwds_tsel_e;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_HOLD = 2'b01,
        ST_RUN = 2'b10
    } wwds_state_e;

    // strap and pin inputs, all asynchronous to clk_i
    typedef struct packed {
        logic supply_good;
        logic watchdog_trigger_in;
        wwds_tsel_e timeout_select;
        logic ratio_select;
    } wwds_pins_s;

    // open-drain reset pin
    typedef struct packed {
        logic out;
        logic oe;
    } wwds_od_s;

endpackage

// File: hw/wwds_top.sv
// window watchdog with supply-supervised reset sequencing
//
// Operation
// - after supply turns good, hold reset low for release delay, then release
// - supply going bad asserts reset again at once
// - while supply is bad reset stays asserted whatever the trigger does
// - rising or falling trigger edge retriggers the watchdog
// - no retrigger within time-out asserts reset for the release delay
// - watchdog reset restarts the window timer from zero
// - first window after any reset release has no early check
// - first rising trigger edge after release enables the early check
// - with supply good, early or missing trigger drives reset low
// - reset pin is open-drain: driven low or released to pull-up
// - time-out strap picks 0.25 s, 2.5 s or capacitor count
// - short time-out: lower boundary 7.86 ms or 2 ms by ratio strap
// - long time-out: lower boundary 78.2 ms or 19.6 ms by ratio strap
// - upper limit within 0.2-0.3 s or 2-3 s over tolerance
// - capacitor mode lower boundary is window over 25.8 or 64.5
// - trigger edges are recognised only at a following clock cycle
`timescale 1ns/1ns
module wwds_top #(
    parameter logic [31:0] RELEASE_CYC = wwds_pkg::RELEASE_DELAY_CYC,
    parameter logic [31:0] TOUT_SHORT = wwds_pkg::TOUT_SHORT_CYC,
    parameter logic [31:0] TOUT_LONG = wwds_pkg::TOUT_LONG_CYC,
    parameter logic [31:0] LOW_S_RLO = wwds_pkg::LOW_SHORT_RLO_CYC,
    parameter logic [31:0] LOW_S_RHI = wwds_pkg::LOW_SHORT_RHI_CYC,
    parameter logic [31:0] LOW_L_RLO = wwds_pkg::LOW_LONG_RLO_CYC,
    parameter logic [31:0] LOW_L_RHI = wwds_pkg::LOW_LONG_RHI_CYC
)
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire wwds_pkg::wwds_pins_s pins_i,
    input wire logic [31:0] cap_timeout_cyc_i,
    output wwds_pkg::wwds_od_s reset_pin_o
);
    import wwds_pkg::*;

    typedef struct packed {
        logic [31:0] tout;
        logic [31:0] lower;
    } wwds_lim_s;

    // ********************************************************************
    // helper functions
    // ********************************************************************
    // per-bit filter: a bit moves only once stages two and three agree
    function automatic logic [4:0] agree(input logic [4:0] s2,
                                         input logic [4:0] s3,
                                         input logic [4:0] held);
        // both agree: take them; they differ: keep the old value
        agree = (s2 & s3) | (held & (s2 ^ s3));
    endfunction

    // window limits from the straps; an illegal strap code acts as low
    function automatic wwds_lim_s limits(input wwds_pins_s p,
                                         input logic [31:0] cap);
        wwds_lim_s l;
        logic [63:0] ratio;
        l = '0;
        ratio = p.ratio_select ? RATIO_HI_X10 : RATIO_LO_X10;
        case (p.timeout_select)
            TSEL_LOW:
            begin
                l.tout = TOUT_SHORT;
                l.lower = p.ratio_select ? LOW_S_RHI : LOW_S_RLO;
            end
            TSEL_HIGH:
            begin
                l.tout = TOUT_LONG;
                l.lower = p.ratio_select ? LOW_L_RHI : LOW_L_RLO;
            end
            TSEL_CAP:
            begin
                l.tout = cap;
                l.lower = 32'((64'(cap) * RATIO_X10_SCALE) / ratio);
            end
            default:
            begin
                l.tout = TOUT_SHORT;
                l.lower = p.ratio_select ? LOW_S_RHI : LOW_S_RLO;
            end
        endcase
        limits = l;
    endfunction

    // ********************************************************************
    // pin synchronisers
    // ********************************************************************
    wwds_pins_s sync1_r, sync2_r, sync3_r, pins_r;
    wwds_pins_s sync1_nxt, sync2_nxt, sync3_nxt, pins_nxt;

    // three stages; stage one feeds stage two only
    always_comb
    begin
        sync1_nxt = pins_i;
        sync2_nxt = sync1_r;
        sync3_nxt = sync2_r;
        pins_nxt = wwds_pins_s'(agree(sync2_r, sync3_r, pins_r));
    end

    // sync registers
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            sync1_r <= wwds_pins_s'(PINS_RST);
            sync2_r <= wwds_pins_s'(PINS_RST);
            sync3_r <= wwds_pins_s'(PINS_RST);
            pins_r <= wwds_pins_s'(PINS_RST);
        end
        else
        begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            sync3_r <= sync3_nxt;
            pins_r <= pins_nxt;
        end
    end

    // ********************************************************************
    // supervisor state machine
    // ********************************************************************
    wwds_state_e state_r, state_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic armed_r, armed_nxt;
    logic trig_prev_r, trig_prev_nxt;
    logic oe_r, oe_nxt;
    logic good;
    logic trig_edge;
    logic trig_rise;
    wwds_lim_s lim;

    assign good = pins_r.supply_good;
    assign lim = limits(pins_r, cap_timeout_cyc_i);
    // edges seen against the previous cycle's level
    assign trig_edge = pins_r.watchdog_trigger_in ^ trig_prev_r;
    assign trig_rise = pins_r.watchdog_trigger_in & ~trig_prev_r;

    // next state; supply loss outranks every watchdog event
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        armed_nxt = armed_r;
        trig_prev_nxt = pins_r.watchdog_trigger_in;
        unique case (state_r)
            // trigger ignored while supply is bad
            ST_OFF:
            begin
                cnt_nxt = CNT_RST;
                armed_nxt = 1'b0;
                if (good)
                begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                armed_nxt = 1'b0;
                if (!good)
                begin
                    state_nxt = ST_OFF;
                    cnt_nxt = CNT_RST;
                end
                else if (cnt_r >= RELEASE_CYC - 32'h00000001)
                begin
                    state_nxt = ST_RUN;
                    cnt_nxt = CNT_RST;
                end
                else
                begin
                    cnt_nxt = cnt_r + 32'h00000001;
                end
            end
            ST_RUN:
            begin
                if (!good)
                begin
                    state_nxt = ST_OFF;
                    cnt_nxt = CNT_RST;
                end
                else if (trig_edge)
                begin
                    if (armed_r && cnt_r < lim.lower)
                    begin
                        state_nxt = ST_HOLD;
                    end
                    cnt_nxt = CNT_RST;
                    if (trig_rise)
                    begin
                        armed_nxt = 1'b1;
                    end
                end
                else if (cnt_r >= lim.tout - 32'h00000001)
                begin
                    state_nxt = ST_HOLD;
                    cnt_nxt = CNT_RST;
                end
                else
                begin
                    cnt_nxt = cnt_r + 32'h00000001;
                end
            end
            default:
            begin
                state_nxt = ST_OFF;
                cnt_nxt = CNT_RST;
                armed_nxt = 1'b0;
            end
        endcase
        oe_nxt = (state_nxt != ST_RUN);
    end

    // state registers; reset is asserted during system reset
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_r <= ST_OFF;
            cnt_r <= CNT_RST;
            armed_r <= 1'b0;
            trig_prev_r <= 1'b0;
            oe_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            armed_r <= armed_nxt;
            trig_prev_r <= trig_prev_nxt;
            oe_r <= oe_nxt;
        end
    end

    // open-drain: output value low, only the enable moves
    assign reset_pin_o = '{out: 1'b0, oe: oe_r};

    // ********************************************************************
    // assertions
    // ********************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence release_seq;
        (state_r == ST_HOLD) ##1 (state_r == ST_RUN);
    endsequence

    sequence early_seq;
        (state_r == ST_RUN) && good && trig_edge && armed_r &&
            (cnt_r < lim.lower);
    endsequence

    // release only after the full delay
    release_len_a: assert property (release_seq |-> !reset_pin_o.oe &&
        ($past(cnt_r) == RELEASE_CYC - 32'h00000001))
        else $error("reset released before the delay ran out");
    supply_drop_a: assert property ((state_r == ST_RUN) && !good |=>
        (state_r == ST_OFF) && reset_pin_o.oe)
        else $error("supply loss did not assert reset");
    // bad supply keeps reset whatever the trigger
    supply_hold_a: assert property (!good && (state_r == ST_OFF) |=>
        (state_r == ST_OFF) && reset_pin_o.oe[*1])
        else $error("reset freed while supply bad");
    // time-out enters the hold with a cleared counter
    timeout_rst_a: assert property ((state_r == ST_RUN) && good &&
        !trig_edge && (cnt_r == lim.tout - 32'h00000001) |=>
        (state_r == ST_HOLD) && (cnt_r == CNT_RST) ##1 reset_pin_o.oe)
        else $error("missed trigger did not assert reset");
    early_rst_a: assert property (early_seq |=>
        (state_r == ST_HOLD) && reset_pin_o.oe)
        else $error("early trigger not caught");
    first_free_a: assert property (release_seq |-> !armed_r)
        else $error("early check armed in first window");
    rise_arm_a: assert property ((state_r == ST_RUN) && good &&
        trig_rise && !(armed_r && (cnt_r < lim.lower)) |=>
        armed_r && (cnt_r == CNT_RST))
        else $error("rising trigger did not arm check");
    // falling edge also restarts the window
    fall_retrig_a: assert property ((state_r == ST_RUN) && good &&
        trig_edge && !trig_rise && !armed_r |=>
        (state_r == ST_RUN) && (cnt_r == CNT_RST) && !reset_pin_o.oe)
        else $error("falling trigger did not restart window");
    od_low_a: assert property ((reset_pin_o.out == 1'b0) &&
        (reset_pin_o.oe || (state_r == ST_RUN)))
        else $error("open-drain pin driven high");

endmodule

// File: verif/wwds_proc_model.sv
// behavioural supervised processor that retriggers the window watchdog
`timescale 1ns/1ns
module wwds_proc_model
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    output logic trig_o
);
    import wwds_pkg::*;

    // ****************************************************************
    // trigger pin, held low by the board pull-down at power-up
    // ****************************************************************
    logic trig_r = 1'b0;

    assign trig_o = trig_r;

    // gap set by caller
    // one trigger change after a gap; the caller keeps gaps clear of the
    // tolerance bands, since behaviour there is not defined
    task automatic toggle(input int gap);
        repeat (gap) @(posedge clk_i);
        trig_r <= ~trig_r;
    endtask

    // first rise after release
    // a freshly released processor waits for reset, then gives one rising
    // edge; a falling edge goes first when the pin was left high
    task automatic rise_first();
        for (int i = 0; i < 64 && rst_n_i !== 1'b1; i++)
            @(posedge clk_i);
        if (trig_r)
            toggle(2);
        toggle(2);
    endtask
endmodule

// File: verif/wwds_top_tb.sv
// self-checking bench of the window watchdog supervisor
`timescale 1ns/1ns
module wwds_top_tb;
    import wwds_pkg::*;

    // ****************************************************************
    // shortened timing, straps and scoreboard
    // ****************************************************************
    localparam int REL = 32'h14;
    localparam int CAP = 32'ha14;
    // lower boundary and time-out per strap combination
    localparam int LO_T [6] = '{32'h32, 32'ha, 32'h50, 32'h14, 32'h64, 32'h28};
    localparam int TO_T [6] = '{32'hc8, 32'hc8, 32'h190, 32'h190, CAP, CAP};
    typedef struct {logic val; int lo; int hi;} wwds_exp_s;

    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic good = 1'b0;
    logic rsel = 1'b0;
    logic trig;
    logic rst_n_w;
    logic last_oe = 1'b1;
    wwds_tsel_e tsel = TSEL_LOW;
    wwds_pins_s pins;
    wwds_od_s reset_pin_o;
    wwds_exp_s q[$];
    wwds_exp_s e;
    int cyc = 0;
    int cap_cyc = CAP;
    int num_errors = 0;
    int tests_run = 0;

    always #10 clk_i = ~clk_i;
    assign pins = wwds_pins_s'{good, trig, tsel, rsel};
    // open-drain wire with pull-up
    assign rst_n_w = reset_pin_o.oe ? reset_pin_o.out : 1'b1;

    wwds_top #(.RELEASE_CYC(32'(REL)), .TOUT_SHORT(32'hc8),
        .TOUT_LONG(32'h190), .LOW_S_RLO(32'h32), .LOW_S_RHI(32'ha),
        .LOW_L_RLO(32'h50), .LOW_L_RHI(32'h14)) u_wwds_top (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .pins_i(pins),
        .cap_timeout_cyc_i(32'(cap_cyc)),
        .reset_pin_o(reset_pin_o)
    );

    wwds_proc_model u_wwds_proc_model (
        .clk_i(clk_i),
        .rst_n_i(rst_n_w),
        .trig_o(trig)
    );

    // ****************************************************************
    // checking: each reset edge must match the oldest note in time
    // ****************************************************************
    // sampled on the falling edge so the registered pin has settled
    always @(negedge clk_i)
    begin
        cyc++;
        if (!sys_rst_i && reset_pin_o.oe !== last_oe)
        begin
            tests_run++;
            if (q.size() == 0)
            begin
                num_errors++;
                $display("[ERR] reset_oe expected no edge seen %b",
                    reset_pin_o.oe);
            end
            else
            begin
                e = q.pop_front();
                if (reset_pin_o.oe !== e.val || cyc < e.lo ||
                    cyc > e.hi)
                begin
                    num_errors++;
                    $display("[ERR] reset_oe expected %b %0d..%0d seen %b %0d",
                        e.val, e.lo, e.hi, reset_pin_o.oe, cyc);
                end
            end
        end
        if (reset_pin_o.oe === 1'b1 && reset_pin_o.out !== 1'b0)
        begin
            num_errors++;
            $display("[ERR] reset_out expected 0 seen %b", reset_pin_o.out);
        end
        last_oe = reset_pin_o.oe;
    end

    task automatic note(input logic val, input int lo, input int hi);
        q.push_back('{val, lo, hi});
    endtask

    task automatic results();
        if (num_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ****************************************************************
    // one pass per strap combination: supply, early and missing trigger
    // ****************************************************************
    task automatic run_combo(input int k);
        int lo;
        int tout;
        int c;
        int cap;
        lo = LO_T[k];
        tout = TO_T[k];
        @(posedge clk_i);
        // random capacitor count; window over 25.8 or 64.5
        cap = $urandom_range(2600, 2000);
        cap_cyc <= cap;
        if (k >= 4)
        begin
            tout = cap;
            lo = (cap * 10) / (k[0] ? 645 : 258);
        end
        tsel <= (k < 2) ? TSEL_LOW : ((k < 4) ? TSEL_HIGH : TSEL_CAP);
        rsel <= k[0];
        if (k > 0)
        begin
            good <= 1'b0;
            note(1'b1, cyc + 1, cyc + 7);
        end
        repeat (3) u_wwds_proc_model.toggle(2);
        @(posedge clk_i);
        good <= 1'b1;
        note(1'b0, cyc + REL + 1, cyc + REL + 8);
        repeat (REL + 12) @(posedge clk_i);
        // unarmed early edges pass, then the armed window is enforced
        u_wwds_proc_model.rise_first();
        repeat (2)
        begin
            c = $urandom_range(tout - 6, lo + 4);
            u_wwds_proc_model.toggle(c);
        end
        u_wwds_proc_model.toggle(lo - 5);
        c = cyc;
        note(1'b1, c + 1, c + 7);
        note(1'b0, c + REL + 1, c + REL + 8);
        repeat (REL + 12) @(posedge clk_i);
        // timer restarted by the reset, so the full time-out must run
        u_wwds_proc_model.rise_first();
        c = $urandom_range(tout - 6, lo + 4);
        u_wwds_proc_model.toggle(c);
        c = cyc;
        note(1'b1, c + tout, c + tout + 8);
        note(1'b0, c + tout + REL, c + tout + REL + 8);
        repeat (tout + REL + 12) @(posedge clk_i);
    endtask

    initial
    begin
        void'($urandom(91700));
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (int k = 0; k < 6; k++)
            run_combo(k);
        repeat (10) @(posedge clk_i);
        tests_run++;
        if (q.size() != 0)
        begin
            num_errors++;
            $display("[ERR] pending_edges expected 0 seen %0d", q.size());
        end
        results();
    end

    // the whole run needs about 16000 cycles
    initial
    begin
        #1200000;
        num_errors++;
        results();
    end
endmodule
